// File: tb/cec_bus_node.sv
// bus partner: the other nodes sharing a wired-and line
// assumes the clock and reset of the block under test
`timescale 1ns/1ns
module cec_bus_node (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tx_bit,
	input wire logic i_pull_dom,
	input wire logic i_err_frame_req,
	output logic o_rx_bit,
	output logic [7:0] o_discards
);
	// ==========================================================
	// bus level: any dominant driver wins over recessive
	assign o_rx_bit = i_tx_bit & ~i_pull_dom;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) o_discards <= 8'h00;
		else o_discards <= o_discards + {7'h00, i_err_frame_req};
	end
endmodule : cec_bus_node

// File: tb/tb_top.sv
// bench for the error confinement block, one task per scenario
// assumes the bus partner model; apb master inside the bench
`timescale 1ns/1ns
module tb_top;
	import cec_pkg::*;
	logic i_clk = 0, i_sys_rst = 1, psel = 0, pen = 0, pwr = 0, tick = 0, txa = 0;
	logic txb = 1, dom = 0, rx, rcv = 0, need = 0, rxv = 0, z = 0, efr, perr, rdy;
	logic [7:0] padr = 8'h00, nd;
	logic [31:0] pwd = 32'h0, rw = 32'h0, prd, r;
	cec_field_t fld = CEC_FLD_IDLE;
	int miscompares = 0, comparisons = 0;
	wire logic [4:0] ek;
	wire logic rtx, txirq, rxirq, evi, txv, efp, dis;
	wire logic [14:0] crc;
	wire cec_state_t st;
	wire logic [8:0] tec, rec;
	wire logic [31:0] txw;
	wire logic [2:0] p0, p1, p2;
	always #5 i_clk = ~i_clk;
	cec_bus_node u_node (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_bit(txb),
		.i_pull_dom(dom), .i_err_frame_req(efr), .o_rx_bit(rx), .o_discards(nd));
	cec_error_confinement dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(rdy), .o_pslverr(perr), .i_bit_tick(tick), .i_field(fld),
		.i_tx_active(txa), .i_tx_bit(txb), .i_rx_bit(rx), .i_eof_last(z),
		.i_err_flag_seen(z), .i_tx_done(z), .i_rx_done(z), .i_bus_off_recover(rcv),
		.i_tx_word_need(need), .i_rx_word_valid(rxv), .i_rx_word(rw),
		.o_err_frame_req(efr), .o_err_frame_passive(efp), .o_retransmit(rtx),
		.o_discard(dis), .o_err_kind(ek), .o_crc(crc), .o_state(st),
		.o_transmit_error_count(tec), .o_receive_error_count(rec),
		.o_tx_data_request_irq(txirq), .o_receive_data_ready_irq(rxirq),
		.o_event_interrupt(evi), .o_tx_word(txw), .o_tx_word_valid(txv),
		.o_tx_req_priority(p0), .o_rx_rdy_priority(p1), .o_event_priority(p2));
	// ==========================================================
	// verdict and comparison
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	logic perr_q;
	// apb transfer, bounded wait on pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		psel <= 1; pwr <= w; padr <= a; pwd <= d;
		@(posedge i_clk);
		pen <= 1;
		n = 0;
		do begin @(posedge i_clk); n++; end while (rdy !== 1'b1 && n < 20);
		r = prd; perr_q = perr;
		psel <= 0; pen <= 0;
		if (rdy !== 1'b1) begin miscompares++; end_of_test(); end
	endtask : apb
	// one bit tick; outputs settle after the following edge
	task automatic bt(input cec_field_t f, input logic ta, input logic b, input logic d);
		@(posedge i_clk);
		fld <= f; txa <= ta; txb <= b; dom <= d; tick <= 1;
		@(posedge i_clk);
		tick <= 0;
		#1;
	endtask : bt
	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk(st, CEC_ERR_ACTIVE);
		chk({p0, p1, p2}, 9'h124);
		apb(0, CEC_OFS_ERR_COUNT, 0); chk(r, 0);
		apb(0, 8'h40, 0); chk({perr_q, r}, 33'h1_0000_0000);
		apb(1, CEC_OFS_INT_ENABLE, 32'h7);
		bt(CEC_FLD_ARB, 1, 1, 1); chk({ek, tec}, 0);
	endtask : t_reset
	task automatic t_ack_warn;
		bt(CEC_FLD_ACK_SLOT, 1, 1, 0); chk({rtx, efr, ek}, 7'h42);
		repeat (11) bt(CEC_FLD_ACK_SLOT, 1, 1, 0);
		chk(tec, 9'h060);
		apb(0, CEC_OFS_INT_FLAG, 0); chk(r, 32'h2101);
		apb(0, CEC_OFS_VECTOR, 0); chk(r, 32'h44);
		chk(evi, 1);
		apb(1, CEC_OFS_INT_FLAG, 32'h1);
		apb(0, CEC_OFS_INT_FLAG, 0); chk({evi, r}, 33'h2100);
	endtask : t_ack_warn
	task automatic t_passive_off;
		repeat (4) bt(CEC_FLD_ACK_SLOT, 1, 1, 0);
		chk({st, tec}, {CEC_ERR_PASSIVE, 9'h080});
		apb(0, CEC_OFS_INT_FLAG, 0); chk(r, 32'h2401);
		bt(CEC_FLD_ACK_SLOT, 1, 1, 0); chk(tec, 9'h080);
		apb(1, CEC_OFS_INT_FLAG, 32'h1);
		for (int i = 0; i < 16; i++) begin
			bt(CEC_FLD_CTRL_DATA, 1, 1, 1);
			if (i == 0) chk({efr, efp, ek}, 7'h61);
			bt(CEC_FLD_IDLE, 1, 1, 0);
		end
		chk({st, tec}, {CEC_BUS_OFF, 9'h100});
		apb(0, CEC_OFS_INT_FLAG, 0); chk(r, 32'h3401);
		bt(CEC_FLD_CTRL_DATA, 1, 1, 1); chk(ek, 0);
		@(posedge i_clk); rcv <= 1; @(posedge i_clk); rcv <= 0; #1;
		@(posedge i_clk); #1; chk({st, tec, rec}, 0);
	endtask : t_passive_off
	task automatic t_stuff;
		logic [7:0] d0;
		d0 = nd;
		bt(CEC_FLD_ARB, 0, 1, 0);
		for (int i = 0; i < 6; i++) begin
			bt(CEC_FLD_CTRL_DATA, 0, 1, 1); chk(ek, (i == 5) ? 5'h08 : 5'h00);
		end
		chk({efr, rec}, 10'h201);
		@(posedge i_clk); #1; chk(nd, d0 + 8'h01);
	endtask : t_stuff
	// receiver form error at crc delimiter, then crc mismatch
	task automatic t_form_crc;
		bt(CEC_FLD_IDLE, 0, 1, 0);
		bt(CEC_FLD_CRC_DELIM, 0, 1, 1); chk({dis, ek}, 6'h24);
		bt(CEC_FLD_IDLE, 0, 1, 0);
		bt(CEC_FLD_ARB, 0, 1, 0); chk(crc, CEC_CRC_POLY);
		bt(CEC_FLD_CRC_DELIM, 0, 1, 0); chk({ek, rec}, 14'h2003);
	endtask : t_form_crc
	task automatic t_dma;
		@(posedge i_clk); rxv <= 1; rw <= 32'hA5C3_0F1E;
		@(posedge i_clk); rxv <= 0; need <= 1; #1;
		chk({rxirq, txirq}, 2'h2);
		@(posedge i_clk); need <= 0; #1;
		chk({rxirq, txirq}, 2'h1);
		apb(1, CEC_OFS_PRIORITY, 32'h0000_0356);
		#1; chk({p0, p1, p2}, 9'h1AB);
		apb(0, CEC_OFS_RX_DATA, 0); chk(r, 32'hA5C3_0F1E);
		apb(1, CEC_OFS_TX_DATA, 32'h1234_ABCD);
		#1; chk({txv, txw}, 33'h1_1234_ABCD);
	endtask : t_dma
	initial begin
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 0;
		@(posedge i_clk); #1;
		t_reset();
		t_ack_warn();
		t_passive_off();
		t_stuff();
		t_form_crc();
		t_dma();
		end_of_test();
	end
endmodule : tb_top

// File: verilog/cec_error_confinement.sv
// CAN error detection and fault confinement with error status flags,
// error interrupt and per-word DMA data request interrupts
// assumes a protocol engine that gives one sample tick per bit with the field
// code, driven and monitored level; APB master in the same clock domain
//
// Behaviour
// - while sending, flag a bit error when read-back level differs from driven
// - no bit error for recessive sent, dominant read in arbitration or ack slot
// - passive error frame sender ignores dominant read back
// - transmitter sees recessive ack slot: ack error, retransmit, no error frame
// - illegal bit in fixed-form field is a form error, except receiver last eof bit
// - sixth equal consecutive bit in stuffed fields is a stuffing error
// - compute frame crc; receiver flags crc error on mismatch
// - detected error starts an error frame; others' error frame discards message
// - separate transmit and receive error counters, transmit faults weigh more
// - error active after reset, error passive once a counter reaches 127
// - bus-off once the transmit counter exceeds 255
// - active node sends active error frame, passive one passive; bus-off sends nothing
// - transmit passive flag tracks count at or above 128, raises error flag on entry
// - receive passive flag tracks count at or above 128, raises error flag on entry
// - transmit bus-off flag set at 256 or more, raising the error flag
// - transmit warning flag in 96..127, raises error flag on entry
// - receive warning flag in 96..127, raises error flag on entry
// - combined warning while either counter is at or above 96
// - three interrupts, each with enable and priority; only the event interrupt has a vector and a flag
// - one transmit data request per word to load, DMA moves one word
// - one receive data ready per received word, DMA moves it out
// - event interrupt only while an enabled interrupt flag is set
`timescale 1ns/1ns
module cec_error_confinement #(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_bit_tick,
	input wire cec_pkg::cec_field_t i_field,
	input wire logic i_tx_active,
	input wire logic i_tx_bit,
	input wire logic i_rx_bit,
	input wire logic i_eof_last,
	input wire logic i_err_flag_seen,
	input wire logic i_tx_done,
	input wire logic i_rx_done,
	input wire logic i_bus_off_recover,
	input wire logic i_tx_word_need,
	input wire logic i_rx_word_valid,
	input wire logic [31:0] i_rx_word,
	output logic o_err_frame_req,
	output logic o_err_frame_passive,
	output logic o_retransmit,
	output logic o_discard,
	output logic [4:0] o_err_kind,
	output logic [cec_pkg::CEC_CRC_W-1:0] o_crc,
	output cec_pkg::cec_state_t o_state,
	output logic [cec_pkg::CEC_CNT_W-1:0] o_transmit_error_count,
	output logic [cec_pkg::CEC_CNT_W-1:0] o_receive_error_count,
	output logic o_tx_data_request_irq,
	output logic o_receive_data_ready_irq,
	output logic o_event_interrupt,
	output logic [31:0] o_tx_word,
	output logic o_tx_word_valid,
	output logic [cec_pkg::CEC_PRI_W-1:0] o_tx_req_priority,
	output logic [cec_pkg::CEC_PRI_W-1:0] o_rx_rdy_priority,
	output logic [cec_pkg::CEC_PRI_W-1:0] o_event_priority
);
	import cec_pkg::*;

	// ==========================================================
	// functions
	function automatic logic [CEC_CNT_W-1:0] sat_add(input logic [CEC_CNT_W-1:0] a,
		input logic [CEC_CNT_W-1:0] b, input logic [CEC_CNT_W-1:0] top);
		logic [CEC_CNT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = (s > {1'b0, top}) ? top : s[CEC_CNT_W-1:0];
	endfunction : sat_add

	function automatic logic [CEC_CRC_W-1:0] crc_step(input logic [CEC_CRC_W-1:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[CEC_CRC_W-1];
		crc_step = {c[CEC_CRC_W-2:0], 1'b0} ^ (fb ? CEC_CRC_POLY : CEC_CRC_INIT);
	endfunction : crc_step

	function automatic logic in_warn(input logic [CEC_CNT_W-1:0] c);
		in_warn = (c >= CEC_WARN_LIMIT) && (c <= CEC_WARN_TOP);
	endfunction : in_warn

	// ==========================================================
	// state
	logic [CEC_CNT_W-1:0] tec;
	logic [CEC_CNT_W-1:0] rec;
	logic [CEC_CNT_W-1:0] next_tec;
	logic [CEC_CNT_W-1:0] next_rec;
	cec_state_t next_state;
	logic transmit_warning_flag;
	logic receive_warning_flag;
	logic transmit_passive_flag;
	logic receive_passive_flag;
	logic transmit_bus_off_flag;
	logic combined_warning_flag;
	logic error_interrupt_flag;
	logic [CEC_IE_W-1:0] int_enable;
	logic [6:0] icode;
	logic [CEC_CRC_W-1:0] crc_rx;
	logic [2:0] run_len;
	logic last_bit;
	logic [31:0] receive_data_register;
	logic [31:0] rdata;
	logic unmapped;

	assign o_transmit_error_count = tec;
	assign o_receive_error_count = rec;

	// ==========================================================
	// bit-level classification
	logic tick;
	logic stuffed;
	logic stuff_bit;
	logic bit_err;
	logic ack_err;
	logic form_err;
	logic stuff_err;
	logic crc_err;
	logic any_err;
	logic tx_fault;
	logic rx_fault;
	logic next_tw;
	logic next_rw;
	logic next_tp;
	logic next_rp;
	logic next_tb;
	logic entry;

	assign tick = i_bit_tick && (o_state != CEC_BUS_OFF);
	assign stuffed = (i_field == CEC_FLD_ARB) || (i_field == CEC_FLD_CTRL_DATA) ||
		(i_field == CEC_FLD_CRC);
	assign stuff_bit = stuffed && (run_len == CEC_STUFF_RUN) && (i_rx_bit != last_bit);

	// bit error with arbitration, ack slot and passive error frame exceptions
	// read-back mismatch
	always_comb begin
		bit_err = tick && i_tx_active && (i_tx_bit != i_rx_bit);
		if ((i_tx_bit == CEC_RECESSIVE) &&
			((i_field == CEC_FLD_ARB) || (i_field == CEC_FLD_ACK_SLOT))) begin
			bit_err = 1'b0;
		end
		if ((i_field == CEC_FLD_ERR_FRAME) && (o_state == CEC_ERR_PASSIVE) &&
			(i_rx_bit == CEC_DOMINANT)) begin
			bit_err = 1'b0;
		end
	end

	assign ack_err = tick && i_tx_active && (i_field == CEC_FLD_ACK_SLOT) &&
		(i_rx_bit == CEC_RECESSIVE);
	assign form_err = tick && (i_rx_bit == CEC_DOMINANT) &&
		((i_field == CEC_FLD_CRC_DELIM) || (i_field == CEC_FLD_ACK_DELIM) ||
		(i_field == CEC_FLD_IFS) ||
		((i_field == CEC_FLD_EOF) && !(!i_tx_active && i_eof_last)));
	assign stuff_err = tick && stuffed && (run_len == CEC_STUFF_RUN) &&
		(i_rx_bit == last_bit);
	assign crc_err = tick && !i_tx_active && (i_field == CEC_FLD_CRC_DELIM) &&
		(o_crc != crc_rx);
	assign any_err = bit_err || ack_err || form_err || stuff_err || crc_err;
	// passive transmitter ack error leaves the count alone
	assign tx_fault = any_err && i_tx_active &&
		!(ack_err && (o_state == CEC_ERR_PASSIVE));
	assign rx_fault = any_err && !i_tx_active;

	// ==========================================================
	// stuffing run length and crc
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !stuffed) begin
			run_len <= CEC_RUN_NONE;
			last_bit <= CEC_RECESSIVE;
		end else if (i_bit_tick) begin
			run_len <= (i_rx_bit == last_bit && run_len != CEC_RUN_NONE) ?
				run_len + CEC_RUN_ONE : CEC_RUN_ONE;
			last_bit <= i_rx_bit;
		end
	end

	// crc over destuffed bits, received crc shifted in
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_field == CEC_FLD_IDLE || i_field == CEC_FLD_IFS) begin
			o_crc <= CEC_CRC_INIT;
			crc_rx <= CEC_CRC_INIT;
		end else if (i_bit_tick && !stuff_bit) begin
			if (i_field == CEC_FLD_ARB || i_field == CEC_FLD_CTRL_DATA) begin
				o_crc <= crc_step(o_crc, i_rx_bit);
			end
			if (i_field == CEC_FLD_CRC) begin
				crc_rx <= {crc_rx[CEC_CRC_W-2:0], i_rx_bit};
			end
		end
	end

	// ==========================================================
	// fault confinement counters
	always_comb begin
		next_tec = tec;
		next_rec = rec;
		if (i_bus_off_recover && o_state == CEC_BUS_OFF) begin
			next_tec = CEC_ZERO;
			next_rec = CEC_ZERO;
		end else begin
			if (tx_fault) begin
				next_tec = sat_add(tec, CEC_TX_INC, CEC_BUS_OFF_LIMIT + CEC_TX_INC);
			end else if (i_tx_done && tec != CEC_ZERO && o_state != CEC_BUS_OFF) begin
				next_tec = tec - CEC_DEC;
			end
			if (rx_fault) begin
				next_rec = sat_add(rec, CEC_RX_INC, CEC_REC_MAX);
			end else if (i_rx_done && rec > CEC_PASSIVE_STATE) begin
				next_rec = CEC_REC_RELOAD;
			end else if (i_rx_done && rec != CEC_ZERO) begin
				next_rec = rec - CEC_DEC;
			end
		end
		// passive at 127, bus-off above 255
		if (next_tec >= CEC_BUS_OFF_LIMIT) begin
			next_state = CEC_BUS_OFF;
		end else if (next_tec >= CEC_PASSIVE_STATE || next_rec >= CEC_PASSIVE_STATE) begin
			next_state = CEC_ERR_PASSIVE;
		end else begin
			next_state = CEC_ERR_ACTIVE;
		end
		next_tw = in_warn(next_tec);
		next_rw = in_warn(next_rec);
		next_tp = next_tec >= CEC_PASSIVE_FLAG;
		next_rp = next_rec >= CEC_PASSIVE_FLAG;
		next_tb = next_tec >= CEC_BUS_OFF_LIMIT;
		entry = (next_tw && !transmit_warning_flag) || (next_rw && !receive_warning_flag) ||
			(next_tp && !transmit_passive_flag) || (next_rp && !receive_passive_flag) ||
			(next_tb && !transmit_bus_off_flag);
	end

	// counters, state and flags in one edge
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tec <= CEC_ZERO;
			rec <= CEC_ZERO;
			o_state <= CEC_ERR_ACTIVE;
			transmit_warning_flag <= 1'b0;
			receive_warning_flag <= 1'b0;
			transmit_passive_flag <= 1'b0;
			receive_passive_flag <= 1'b0;
			transmit_bus_off_flag <= 1'b0;
			combined_warning_flag <= 1'b0;
		end else begin
			tec <= next_tec;
			rec <= next_rec;
			o_state <= next_state;
			transmit_warning_flag <= next_tw;
			receive_warning_flag <= next_rw;
			transmit_passive_flag <= next_tp;
			receive_passive_flag <= next_rp;
			transmit_bus_off_flag <= next_tb;
			combined_warning_flag <= (next_tec >= CEC_WARN_LIMIT) || (next_rec >= CEC_WARN_LIMIT);
		end
	end

	// ==========================================================
	// error frame signalling towards the engine
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_err_frame_req <= 1'b0;
			o_err_frame_passive <= 1'b0;
			o_retransmit <= 1'b0;
			o_discard <= 1'b0;
			o_err_kind <= '0;
		end else begin
			// error frame unless ack error; bus-off never reaches here
			o_err_frame_req <= any_err && !ack_err;
			o_err_frame_passive <= (o_state == CEC_ERR_PASSIVE);
			o_retransmit <= ack_err;
			o_discard <= (any_err && !ack_err) || (i_err_flag_seen && o_state != CEC_BUS_OFF);
			o_err_kind <= {crc_err, stuff_err, form_err, ack_err, bit_err};
		end
	end

	// ==========================================================
	// APB slave, no wait state, registered answer
	logic setup;
	logic wr;
	assign setup = i_psel && !i_penable && !o_pready;
	assign wr = i_psel && i_penable && o_pready && i_pwrite;

	always_comb begin
		rdata = CEC_WORD_RESET;
		unmapped = 1'b0;
		unique case (i_paddr[7:0])
			CEC_OFS_ERR_COUNT: begin
				rdata[CEC_EC_TX_LSB +: CEC_CNT_W] = tec;
				rdata[CEC_EC_RX_LSB +: CEC_CNT_W] = rec;
			end
			CEC_OFS_INT_FLAG: begin
				rdata[CEC_IF_ERR] = error_interrupt_flag;
				rdata[CEC_IF_TX_WARN] = transmit_warning_flag;
				rdata[CEC_IF_RX_WARN] = receive_warning_flag;
				rdata[CEC_IF_TX_PASS] = transmit_passive_flag;
				rdata[CEC_IF_RX_PASS] = receive_passive_flag;
				rdata[CEC_IF_TX_BOFF] = transmit_bus_off_flag;
				rdata[CEC_IF_WARN] = combined_warning_flag;
			end
			CEC_OFS_INT_ENABLE: rdata[CEC_IE_W-1:0] = int_enable;
			CEC_OFS_VECTOR: rdata[6:0] = icode;
			CEC_OFS_PRIORITY: begin
				rdata[CEC_PRI_TX_LSB +: CEC_PRI_W] = o_tx_req_priority;
				rdata[CEC_PRI_RX_LSB +: CEC_PRI_W] = o_rx_rdy_priority;
				rdata[CEC_PRI_EV_LSB +: CEC_PRI_W] = o_event_priority;
			end
			CEC_OFS_TX_DATA: rdata = o_tx_word;
			CEC_OFS_RX_DATA: rdata = receive_data_register;
			default: unmapped = 1'b1;
		endcase
	end

	// handshake and read data
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pready <= 1'b0;
			o_prdata <= CEC_WORD_RESET;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			o_pslverr <= setup && unmapped;
			o_prdata <= (setup && !i_pwrite) ? rdata : CEC_WORD_RESET;
		end
	end

	// writable control registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			int_enable <= CEC_IE_RESET;
			o_tx_req_priority <= CEC_PRI_RESET;
			o_rx_rdy_priority <= CEC_PRI_RESET;
			o_event_priority <= CEC_PRI_RESET;
			o_tx_word <= CEC_WORD_RESET;
			o_tx_word_valid <= 1'b0;
		end else begin
			o_tx_word_valid <= wr && (i_paddr[7:0] == CEC_OFS_TX_DATA);
			if (wr && i_paddr[7:0] == CEC_OFS_INT_ENABLE) begin
				int_enable <= i_pwdata[CEC_IE_W-1:0];
			end
			if (wr && i_paddr[7:0] == CEC_OFS_PRIORITY) begin
				o_tx_req_priority <= i_pwdata[CEC_PRI_TX_LSB +: CEC_PRI_W];
				o_rx_rdy_priority <= i_pwdata[CEC_PRI_RX_LSB +: CEC_PRI_W];
				o_event_priority <= i_pwdata[CEC_PRI_EV_LSB +: CEC_PRI_W];
			end
			if (wr && i_paddr[7:0] == CEC_OFS_TX_DATA) begin
				o_tx_word <= i_pwdata;
			end
		end
	end

	// ==========================================================
	// interrupts
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			error_interrupt_flag <= 1'b0;
		end else if (entry) begin
			// set on entry, wins over clear
			error_interrupt_flag <= 1'b1;
		end else if (wr && i_paddr[7:0] == CEC_OFS_INT_FLAG && i_pwdata[CEC_IF_ERR]) begin
			error_interrupt_flag <= 1'b0;
		end
	end

	// event line, vector and DMA data requests
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_event_interrupt <= 1'b0;
			icode <= CEC_ICODE_NONE;
			o_tx_data_request_irq <= 1'b0;
			o_receive_data_ready_irq <= 1'b0;
			receive_data_register <= CEC_WORD_RESET;
		end else begin
			o_event_interrupt <= error_interrupt_flag && int_enable[CEC_IE_ERR];
			icode <= (error_interrupt_flag && int_enable[CEC_IE_ERR]) ?
				CEC_ICODE_ERR : CEC_ICODE_NONE;
			o_tx_data_request_irq <= i_tx_word_need && int_enable[CEC_IE_TXREQ];
			o_receive_data_ready_irq <= i_rx_word_valid && int_enable[CEC_IE_RXRDY];
			if (i_rx_word_valid) begin
				receive_data_register <= i_rx_word;
			end
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_tx_warn_range: assert property (transmit_warning_flag == in_warn(tec))
		else $error("transmit warning flag disagrees with count");
	a_rx_passive_flag: assert property (receive_passive_flag == (rec >= CEC_PASSIVE_FLAG))
		else $error("receive passive flag disagrees with count");
	a_bus_off_state: assert property ((tec >= CEC_BUS_OFF_LIMIT) == (o_state == CEC_BUS_OFF))
		else $error("bus-off state disagrees with count");
	a_combined_warn: assert property (combined_warning_flag ==
		((tec >= CEC_WARN_LIMIT) || (rec >= CEC_WARN_LIMIT)))
		else $error("combined warning wrong");
	a_error_interrupt_flag_on_entry: assert property ($rose(transmit_passive_flag) |-> error_interrupt_flag)
		else $error("error flag not raised on passive entry");
	a_bus_off_silent: assert property (o_state == CEC_BUS_OFF |=> !o_err_frame_req)
		else $error("bus-off node requested an error frame");
	a_ack_no_frame: assert property (ack_err |=> o_retransmit && !o_err_frame_req)
		else $error("ack error mishandled");
	a_arb_no_biterr: assert property (i_bit_tick && i_tx_active && i_tx_bit == CEC_RECESSIVE &&
		i_field == CEC_FLD_ARB |-> ##1 !o_err_kind[0])
		else $error("bit error raised in arbitration");
	a_tx_step_eight: assert property (tx_fault && !i_bus_off_recover && tec < CEC_BUS_OFF_LIMIT
		|=> tec == $past(tec) + CEC_TX_INC)
		else $error("transmit count did not step by eight");
	a_event_gate: assert property (o_event_interrupt |->
		$past(error_interrupt_flag) && $past(int_enable[CEC_IE_ERR]))
		else $error("event interrupt without enabled flag");
	a_rx_ready_once: assert property (i_rx_word_valid && int_enable[CEC_IE_RXRDY] |=>
		o_receive_data_ready_irq)
		else $error("receive ready missing");

	c_bus_off: cover property (o_state == CEC_BUS_OFF);
	c_error_interrupt_flag_cleared: cover property (error_interrupt_flag ##1 !error_interrupt_flag);
	c_stuff_err: cover property (stuff_err);
	c_crc_err: cover property (crc_err);

endmodule : cec_error_confinement

// File: verilog/cec_pkg.sv
// constants and types of the CAN error confinement block
// assumes a single 100 MHz module clock and APB register access
package cec_pkg;

	// ==========================================================
	// counter widths and limits
	localparam int CEC_CNT_W = 9;
	localparam logic [8:0] CEC_WARN_LIMIT = 9'h060;
	localparam logic [8:0] CEC_WARN_TOP = 9'h07F;
	localparam logic [8:0] CEC_PASSIVE_STATE = 9'h07F;
	localparam logic [8:0] CEC_PASSIVE_FLAG = 9'h080;
	localparam logic [8:0] CEC_BUS_OFF_LIMIT = 9'h100;
	localparam logic [8:0] CEC_TX_INC = 9'h008;
	localparam logic [8:0] CEC_RX_INC = 9'h001;
	localparam logic [8:0] CEC_DEC = 9'h001;
	localparam logic [8:0] CEC_REC_RELOAD = 9'h077;
	localparam logic [8:0] CEC_REC_MAX = 9'h0FF;
	localparam logic [8:0] CEC_ZERO = 9'h000;

	// ==========================================================
	// bus levels, stuffing and crc
	localparam logic CEC_RECESSIVE = 1'b1;
	localparam logic CEC_DOMINANT = 1'b0;
	localparam logic [2:0] CEC_STUFF_RUN = 3'h5;
	localparam logic [2:0] CEC_RUN_ONE = 3'h1;
	localparam logic [2:0] CEC_RUN_NONE = 3'h0;
	localparam int CEC_CRC_W = 15;
	localparam logic [14:0] CEC_CRC_POLY = 15'h4599;
	localparam logic [14:0] CEC_CRC_INIT = 15'h0000;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] CEC_OFS_ERR_COUNT = 8'h00;
	localparam logic [7:0] CEC_OFS_INT_FLAG = 8'h04;
	localparam logic [7:0] CEC_OFS_INT_ENABLE = 8'h08;
	localparam logic [7:0] CEC_OFS_VECTOR = 8'h0C;
	localparam logic [7:0] CEC_OFS_PRIORITY = 8'h10;
	localparam logic [7:0] CEC_OFS_TX_DATA = 8'h14;
	localparam logic [7:0] CEC_OFS_RX_DATA = 8'h18;

	// ==========================================================
	// field positions
	localparam int CEC_EC_TX_LSB = 0;
	localparam int CEC_EC_RX_LSB = 16;
	localparam int CEC_IF_ERR = 0;
	localparam int CEC_IF_TX_WARN = 8;
	localparam int CEC_IF_RX_WARN = 9;
	localparam int CEC_IF_TX_PASS = 10;
	localparam int CEC_IF_RX_PASS = 11;
	localparam int CEC_IF_TX_BOFF = 12;
	localparam int CEC_IF_WARN = 13;
	localparam int CEC_IE_ERR = 0;
	localparam int CEC_IE_TXREQ = 1;
	localparam int CEC_IE_RXRDY = 2;
	localparam int CEC_PRI_W = 3;
	localparam int CEC_PRI_TX_LSB = 0;
	localparam int CEC_PRI_RX_LSB = 4;
	localparam int CEC_PRI_EV_LSB = 8;
	localparam int CEC_IE_W = 3;

	// ==========================================================
	// reset values and interrupt codes
	localparam logic [2:0] CEC_IE_RESET = 3'h0;
	localparam logic [2:0] CEC_PRI_RESET = 3'h4;
	localparam logic [6:0] CEC_ICODE_NONE = 7'h40;
	localparam logic [6:0] CEC_ICODE_ERR = 7'h44;
	localparam logic [31:0] CEC_WORD_RESET = 32'h0000_0000;

	// ==========================================================
	// frame field as reported by the protocol engine per bit
	typedef enum logic [3:0] {
		CEC_FLD_IDLE, CEC_FLD_ARB, CEC_FLD_CTRL_DATA, CEC_FLD_CRC, CEC_FLD_CRC_DELIM,
		CEC_FLD_ACK_SLOT, CEC_FLD_ACK_DELIM, CEC_FLD_EOF, CEC_FLD_IFS, CEC_FLD_ERR_FRAME
	} cec_field_t;

	// fault confinement state
	typedef enum logic [1:0] {CEC_ERR_ACTIVE, CEC_ERR_PASSIVE, CEC_BUS_OFF} cec_state_t;

endpackage : cec_pkg
